// file: fan_pwm_cfg_pkg.sv
// Purpose: Shared constants for the fan PWM frequency, slope and
//          smoothing configuration block.
// Assumes: 40 MHz reference clock; Avalon-MM byte addressing.
// Notes:   Register indexes are word indexes; byte address = 4 * index.

package fan_pwm_cfg_pkg;

    // ==========================================================
    // Clock
    // ==========================================================
    localparam longint CLK_KHZ             = 40000;

    // ==========================================================
    // Register indexes (byte address is four times the index)
    // ==========================================================
    localparam logic [6:0] IDX_REMOTE1_SLOPE = 7'h5F;
    localparam logic [6:0] IDX_LOCAL_SLOPE   = 7'h60;
    localparam logic [6:0] IDX_REMOTE2_SLOPE = 7'h61;
    localparam logic [6:0] IDX_ACOUSTIC_ONE  = 7'h62;
    localparam logic [6:0] IDX_CONFIG_SIX    = 7'h10;
    localparam int         ADDR_W            = 9;

    // ==========================================================
    // Values after reset
    // ==========================================================
    localparam logic [7:0] SLOPE_RESET       = 8'hC4;
    localparam logic [7:0] ACOUSTIC_RESET    = 8'h00;
    localparam logic       SLOT_LONG_RESET   = 1'b0;

    // ==========================================================
    // Field positions, frequency/slope registers
    // ==========================================================
    localparam int RATE_LSB          = 0;
    localparam int FAST_DRIVE_BIT    = 3;
    localparam int SPAN_LSB          = 4;

    // ==========================================================
    // Field positions, acoustic smoothing register one and config register six
    // ==========================================================
    localparam int RAMP_RATE_LSB     = 0;
    localparam int SMOOTH_ON_BIT     = 3;
    localparam int SYNC_BIT          = 4;
    localparam int FLOOR_LSB         = 5;
    localparam int SLOT_LONG_BIT     = 7;

    // ==========================================================
    // Ramp timing: full 0..100% ramp at the smallest increment
    // ==========================================================
    localparam longint RAMP_FULL_MS_STD  = 37500;
    localparam longint RAMP_FULL_MS_LONG = 52200;
    localparam longint DUTY_FULL_STEPS   = 255;
    // Longest time, so round down
    localparam longint SLOT_CYCLES_STD   =
        RAMP_FULL_MS_STD * CLK_KHZ / DUTY_FULL_STEPS;
    localparam longint SLOT_CYCLES_LONG  =
        RAMP_FULL_MS_LONG * CLK_KHZ / DUTY_FULL_STEPS;
    localparam int     SLOT_CNT_W        = 24;

endpackage

// file: duty_ramp_smoother.sv
// Purpose: Ramps a duty value toward its target once per time slot.
// Assumes: Target is re-evaluated by the caller every clock.
// Notes:   Bypassed (duty follows target) while smoothing is off.

`timescale 1ns/10ps
`default_nettype none

module duty_ramp_smoother
    import fan_pwm_cfg_pkg::*;
#(
    parameter longint SLOT_STD  = SLOT_CYCLES_STD,
    parameter longint SLOT_LONG = SLOT_CYCLES_LONG
) (
    input  wire logic       i_ref_clk,
    input  wire logic       i_rstn,
    input  wire logic       i_enable,
    input  wire logic       i_slot_long,
    input  wire logic [2:0] i_rate_code,
    input  wire logic [7:0] i_target,
    output logic      [7:0] o_duty
);

    // ==========================================================
    // Step decode
    // ==========================================================
    function automatic logic [7:0] ramp_step(input logic [2:0] code);
        unique case (code)
            3'h0: ramp_step = 8'h01;
            3'h1: ramp_step = 8'h02;
            3'h2: ramp_step = 8'h03;
            3'h3: ramp_step = 8'h04;
            3'h4: ramp_step = 8'h08;
            3'h5: ramp_step = 8'h0C;
            3'h6: ramp_step = 8'h18;
            3'h7: ramp_step = 8'h30;
        endcase
    endfunction

    typedef struct packed {
        logic [SLOT_CNT_W-1:0] cnt;
        logic [7:0]            duty;
    } smooth_state_t;

    smooth_state_t st;
    smooth_state_t next_st;

    logic [SLOT_CNT_W-1:0] slot_last;
    logic                  slot_end;
    logic [7:0]            step;

    assign slot_last = i_slot_long ? SLOT_CNT_W'(SLOT_LONG - 1)
                                   : SLOT_CNT_W'(SLOT_STD - 1);
    assign slot_end  = (st.cnt >= slot_last);
    assign step      = ramp_step(i_rate_code);
    assign o_duty    = st.duty;

    // ==========================================================
    // Slot timer and step toward target
    // ==========================================================
    always_comb begin
        next_st = st;
        if (!i_enable) begin
            next_st.cnt  = '0;
            next_st.duty = i_target;
        end else if (slot_end) begin
            next_st.cnt = '0;
            // Clamp at target so a large step never overshoots
            if (i_target > st.duty) begin
                if (i_target - st.duty <= step) begin
                    next_st.duty = i_target;
                end else begin
                    next_st.duty = st.duty + step;
                end
            end else if (i_target < st.duty) begin
                if (st.duty - i_target <= step) begin
                    next_st.duty = i_target;
                end else begin
                    next_st.duty = st.duty - step;
                end
            end
        end else begin
            next_st.cnt = st.cnt + 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    property p_bypass_follows;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        !i_enable |=> o_duty == $past(i_target);
    endproperty
    a_bypass_follows: assert property (p_bypass_follows)
        else $error("duty does not follow target with smoothing off");

    property p_step_size;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (i_enable && slot_end && i_target > st.duty
         && i_target - st.duty > step)
        |=> o_duty == $past(st.duty) + $past(step);
    endproperty
    a_step_size: assert property (p_step_size)
        else $error("ramp step differs from selected increment");

    property p_no_overshoot;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (i_enable && st.duty < i_target)
        |=> (o_duty <= $past(i_target)) && (o_duty >= $past(st.duty));
    endproperty
    a_no_overshoot: assert property (p_no_overshoot)
        else $error("ramp passed its target");

    property p_hold_in_slot;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (i_enable && !slot_end && $past(i_enable)) |=> $stable(o_duty);
    endproperty
    a_hold_in_slot: assert property (p_hold_in_slot)
        else $error("duty changed inside a time slot");

    property p_slot_long_len;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (i_enable && i_slot_long && slot_end)
        |-> st.cnt >= SLOT_CNT_W'(SLOT_LONG - 1);
    endproperty
    a_slot_long_len: assert property (p_slot_long_len)
        else $error("long time slot ended early");

endmodule // duty_ramp_smoother

`default_nettype wire

// file: fan_pwm_pwm_rate_code_slope_smoothing.sv
// Purpose: Frequency, slope and acoustic smoothing configuration for
//          three fan PWM channels, reached over Avalon-MM.
// Assumes: Lock level and duty/threshold inputs are synchronous.
// Notes:   Every bus access sees exactly one wait cycle.
// Function
// - Once locked, writes to the frequency/slope registers are ignored.
// - A 3-bit code per channel selects one of eight low PWM rates.
// - Each frequency/slope register comes out of reset as 0xC4.
// - The drive-type bit selects fast drive and disables stretching.
// - A 4-bit code per channel selects the automatic temperature span.
// - Remote 1 duty ramps by a selectable increment per time slot.
// - With the slot-length bit clear the slot gives the shorter ramps.
// - With the slot-length bit set the slot gives the longer ramps.
// - Remote 1 ramping is applied only while its enable bit is set.
// - The sync bit adds speed input two to the PWM3-synced inputs.
// - Below threshold in auto mode PWM1 gives zero or its minimum.
// - Below threshold in auto mode PWM2 gives zero or its minimum.
// - Below threshold in auto mode PWM3 gives zero or its minimum.
// - The three registers serve Remote 1, local and Remote 2 in order.
//
// Implementation choice: the Avalon-MM register port.

`timescale 1ns/10ps
`default_nettype none

module fan_pwm_pwm_rate_code_slope_smoothing
    import fan_pwm_cfg_pkg::*;
#(
    parameter longint SLOT_STD  = SLOT_CYCLES_STD,
    parameter longint SLOT_LONG = SLOT_CYCLES_LONG
) (
    input  wire logic            i_ref_clk,
    input  wire logic            i_rstn,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0] i_address,
    input  wire logic            i_read,
    input  wire logic            i_write,
    input  wire logic [31:0]     i_writedata,
    input  wire logic [3:0]      i_byteenable,
    output logic      [31:0]     o_readdata,
    output logic                 o_waitrequest,
    // Lock from the global configuration register
    input  wire logic            i_config_lock,
    // Automatic control inputs, index 0 = PWM1
    input  wire logic [2:0]      i_auto_mode,
    input  wire logic [2:0]      i_below_start,
    input  wire logic [2:0][7:0] i_auto_duty,
    input  wire logic [2:0][7:0] i_min_duty,
    // Per channel configuration, index 0 = PWM1
    output logic      [2:0][2:0] o_pwm_rate_code,
    output logic      [2:0]      o_fast_drive_select,
    output logic      [2:0]      o_stretch_enable,
    output logic      [2:0][3:0] o_temp_span_code,
    // Bit 0 = speed_input_two, 1 = three, 2 = four
    output logic      [2:0]      o_sync_speed_inputs,
    output logic                 o_remote1_smoothing_on,
    output logic      [2:0]      o_remote1_ramp_rate,
    output logic      [7:0]      o_pwm1_duty,
    output logic      [7:0]      o_pwm2_duty,
    output logic      [7:0]      o_pwm3_duty
);

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic [2:0][7:0] slope;
        logic [7:0]      acou;
        logic            slot_long;
        logic            ack;
        logic [31:0]     rdata;
        logic [2:0][7:0] target;
    } cfg_state_t;

    localparam cfg_state_t STATE_RESET = '{
        slope:     {3{SLOPE_RESET}},
        acou:      ACOUSTIC_RESET,
        slot_long: SLOT_LONG_RESET,
        ack:       1'b0,
        rdata:     32'h0000_0000,
        target:    '0
    };

    cfg_state_t st;
    cfg_state_t next_st;

    logic [6:0] word_idx;
    logic       req_new;
    logic       wr_take;
    logic       first_floor;
    logic       second_floor;
    logic       third_floor;

    // ==========================================================
    // Address decode, shared by read and write paths
    // ==========================================================
    // Returns channel 0..2 for a frequency/slope register, 3 otherwise
    function automatic logic [1:0] slope_channel(input logic [6:0] idx);
        if (idx == IDX_REMOTE1_SLOPE) begin
            slope_channel = 2'h0;
        end else if (idx == IDX_LOCAL_SLOPE) begin
            slope_channel = 2'h1;
        end else if (idx == IDX_REMOTE2_SLOPE) begin
            slope_channel = 2'h2;
        end else begin
            slope_channel = 2'h3;
        end
    endfunction

    assign word_idx      = i_address[ADDR_W-1:2];
    // One wait cycle per access; the second edge completes it
    assign req_new       = (i_read || i_write) && !st.ack;
    assign o_waitrequest = req_new;
    assign wr_take       = i_write && st.ack && i_byteenable[0];
    assign o_readdata    = st.rdata;

    assign first_floor   = st.acou[FLOOR_LSB];
    assign second_floor  = st.acou[FLOOR_LSB+1];
    assign third_floor   = st.acou[FLOOR_LSB+2];

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        next_st     = st;
        next_st.ack = req_new;

        // Read data is latched on the wait cycle and held to the answer
        if (i_read && !st.ack) begin
            next_st.rdata = 32'h0000_0000;
            if (slope_channel(word_idx) != 2'h3) begin
                next_st.rdata[7:0] = st.slope[slope_channel(word_idx)];
            end else if (word_idx == IDX_ACOUSTIC_ONE) begin
                next_st.rdata[7:0] = st.acou;
            end else if (word_idx == IDX_CONFIG_SIX) begin
                next_st.rdata[SLOT_LONG_BIT] = st.slot_long;
            end
        end

        // Locked registers silently drop writes; the bus still completes
        if (wr_take && !i_config_lock) begin
            if (slope_channel(word_idx) != 2'h3) begin
                next_st.slope[slope_channel(word_idx)] =
                    i_writedata[7:0];
            end else if (word_idx == IDX_ACOUSTIC_ONE) begin
                next_st.acou = i_writedata[7:0];
            end
        end
        // Slot-length bit lives outside the lockable group
        if (wr_take && word_idx == IDX_CONFIG_SIX) begin
            next_st.slot_long = i_writedata[SLOT_LONG_BIT];
        end

        // Duty below start threshold: off or programmed minimum
        for (int ch = 0; ch < 3; ch++) begin
            if (i_auto_mode[ch] && i_below_start[ch]) begin
                if (st.acou[FLOOR_LSB+ch]) begin
                    next_st.target[ch] = i_min_duty[ch];
                end else begin
                    next_st.target[ch] = 8'h00;
                end
            end else begin
                next_st.target[ch] = i_auto_duty[ch];
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            st <= STATE_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Configuration outputs
    // ==========================================================
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_chan
            assign o_pwm_rate_code[g] =
                st.slope[g][RATE_LSB+2:RATE_LSB];
            assign o_fast_drive_select[g] =
                st.slope[g][FAST_DRIVE_BIT];
            // Stretching only applies to low-frequency 3-wire drive
            assign o_stretch_enable[g] =
                !st.slope[g][FAST_DRIVE_BIT];
            assign o_temp_span_code[g] =
                st.slope[g][SPAN_LSB+3:SPAN_LSB];
        end
    endgenerate

    assign o_sync_speed_inputs    = {2'b11, st.acou[SYNC_BIT]};
    assign o_remote1_smoothing_on = st.acou[SMOOTH_ON_BIT];
    assign o_remote1_ramp_rate    = st.acou[RAMP_RATE_LSB+2:RAMP_RATE_LSB];
    assign o_pwm2_duty            = st.target[1];
    assign o_pwm3_duty            = st.target[2];

    // ==========================================================
    // Remote 1 smoothing on PWM1
    // ==========================================================
    duty_ramp_smoother #(
        .SLOT_STD  (SLOT_STD),
        .SLOT_LONG (SLOT_LONG)
    ) duty_ramp_smoother_inst (
        .i_ref_clk   (i_ref_clk),
        .i_rstn      (i_rstn),
        .i_enable    (st.acou[SMOOTH_ON_BIT]),
        .i_slot_long (st.slot_long),
        .i_rate_code (st.acou[RAMP_RATE_LSB+2:RAMP_RATE_LSB]),
        .i_target    (st.target[0]),
        .o_duty      (o_pwm1_duty)
    );

    // ==========================================================
    // Checks
    // ==========================================================
    property p_lock_blocks_write;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (i_write && !o_waitrequest && i_config_lock
         && word_idx == IDX_LOCAL_SLOPE)
        |=> $stable(o_temp_span_code) && $stable(o_pwm_rate_code);
    endproperty
    a_lock_blocks_write: assert property (p_lock_blocks_write)
        else $error("locked slope register accepted a write");

    property p_rate_write;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (i_write && !o_waitrequest && !i_config_lock && i_byteenable[0]
         && word_idx == IDX_REMOTE1_SLOPE)
        |=> o_pwm_rate_code[0] == $past(i_writedata[2:0]);
    endproperty
    a_rate_write: assert property (p_rate_write)
        else $error("rate code did not take written value");

    property p_reset_value;
        @(posedge i_ref_clk)
        !i_rstn |=> (o_pwm_rate_code[1] == 3'h4)
                 && (o_temp_span_code[2] == 4'hC)
                 && (o_fast_drive_select == 3'h0);
    endproperty
    a_reset_value: assert property (p_reset_value)
        else $error("slope register not at reset value");

    property p_fast_drive;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (i_write && !o_waitrequest && !i_config_lock && i_byteenable[0]
         && word_idx == IDX_REMOTE2_SLOPE && i_writedata[3])
        |=> o_fast_drive_select[2] && !o_stretch_enable[2];
    endproperty
    a_fast_drive: assert property (p_fast_drive)
        else $error("fast drive did not suppress stretching");

    property p_span_map;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (i_write && !o_waitrequest && !i_config_lock && i_byteenable[0]
         && word_idx == IDX_LOCAL_SLOPE)
        |=> o_temp_span_code[1] == $past(i_writedata[7:4]);
    endproperty
    a_span_map: assert property (p_span_map)
        else $error("span code did not reach local channel");

    property p_sync_inputs;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (i_read && !o_waitrequest && word_idx == IDX_ACOUSTIC_ONE)
        |-> o_sync_speed_inputs == {2'b11, o_readdata[SYNC_BIT]};
    endproperty
    a_sync_inputs: assert property (p_sync_inputs)
        else $error("speed input sync mask mismatches register");

    property p_floor_one;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (i_auto_mode[0] && i_below_start[0] && !first_floor)
        |=> st.target[0] == 8'h00;
    endproperty
    a_floor_one: assert property (p_floor_one)
        else $error("PWM1 not off below threshold");

    property p_floor_two;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (i_auto_mode[1] && i_below_start[1] && second_floor)
        |=> o_pwm2_duty == $past(i_min_duty[1]);
    endproperty
    a_floor_two: assert property (p_floor_two)
        else $error("PWM2 not at minimum below threshold");

    property p_floor_three;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (i_auto_mode[2] && i_below_start[2] && !third_floor)
        |=> o_pwm3_duty == 8'h00;
    endproperty
    a_floor_three: assert property (p_floor_three)
        else $error("PWM3 not off below threshold");

    property p_bus_answer;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        ((i_read || i_write) && o_waitrequest) |=> !o_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("bus access not answered after one wait cycle");

endmodule // fan_pwm_pwm_rate_code_slope_smoothing

`default_nettype wire

// file: fan_load.sv
// Purpose: Behavioural fan hung on one PWM output.
// Assumes: Duty full scale is 0..255.
// Notes:   Speed creeps toward duty; it never jumps.
`timescale 1ns/10ps
`default_nettype none
module fan_load (
    input  wire logic       i_ref_clk,
    input  wire logic [7:0] i_duty,
    output var  logic [7:0] o_speed
);
    // ==========================================================
    // Rotor
    // ==========================================================
    // Inertia: one count a clock, so a duty step is seen as a slew
    initial o_speed = 8'h00;
    always @(posedge i_ref_clk) begin
        if (o_speed < i_duty)
            o_speed <= o_speed + 8'h01;
        else if (o_speed > i_duty)
            o_speed <= o_speed - 8'h01;
    end
endmodule // fan_load
`default_nettype wire

// file: fan_pwm_pwm_rate_code_slope_smoothing_tb_top.sv
// Purpose: Self-checking bench for the fan PWM configuration block.
// Assumes: Short time slots (8 and 12 cycles) stand in for real ones.
// Notes:   Outputs are sampled at falling edges, or at the rising edge that ends a bus access.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin \
    n_mismatch++; $display("ERROR %s exp %0h got %0h", nm, e, s); end end
module fan_pwm_pwm_rate_code_slope_smoothing_tb_top;
    import fan_pwm_cfg_pkg::*;
    localparam longint SLOT = 8;
    logic                i_ref_clk = 1'b0;
    logic                i_rstn = 1'b0;
    logic [ADDR_W-1:0]   i_address = '0;
    logic                i_read = 1'b0;
    logic                i_write = 1'b0;
    logic                i_config_lock = 1'b0;
    logic [31:0]         i_writedata = 32'h0;
    logic [3:0]          i_byteenable = 4'hF;
    logic [2:0]          i_auto_mode = 3'h0;
    logic [2:0]          i_below_start = 3'h0;
    logic [2:0][7:0]     i_auto_duty = '0;
    logic [2:0][7:0]     i_min_duty = '0;
    logic [31:0]         o_readdata;
    logic                o_waitrequest;
    logic [2:0][2:0]     o_pwm_rate_code;
    logic [2:0]          o_fast_drive_select;
    logic [2:0]          o_stretch_enable;
    logic [2:0][3:0]     o_temp_span_code;
    logic [2:0]          o_sync_speed_inputs;
    logic                o_remote1_smoothing_on;
    logic [2:0]          o_remote1_ramp_rate;
    logic [7:0]          o_pwm1_duty;
    logic [7:0]          o_pwm2_duty;
    logic [7:0]          o_pwm3_duty;
    logic [2:0][7:0]     dd;
    logic [7:0]          spd;
    int                  n_mismatch = 0;
    int                  n_tests = 0;
    logic [16:0]         lfsr = 17'h1074C;
    logic [7:0]          rd;
    logic [7:0]          v;
    logic [7:0]          sv [3];
    int                  steps [8] = '{1, 2, 3, 4, 8, 12, 24, 48};
    assign dd = {o_pwm3_duty, o_pwm2_duty, o_pwm1_duty};
    always #12.5 i_ref_clk = ~i_ref_clk;
    fan_pwm_pwm_rate_code_slope_smoothing #(.SLOT_STD(SLOT), .SLOT_LONG(12))
        fan_pwm_pwm_rate_code_slope_smoothing_inst (
        .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_address(i_address),
        .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
        .i_byteenable(i_byteenable), .o_readdata(o_readdata),
        .o_waitrequest(o_waitrequest), .i_config_lock(i_config_lock),
        .i_auto_mode(i_auto_mode), .i_below_start(i_below_start),
        .i_auto_duty(i_auto_duty), .i_min_duty(i_min_duty),
        .o_pwm_rate_code(o_pwm_rate_code),
        .o_fast_drive_select(o_fast_drive_select),
        .o_stretch_enable(o_stretch_enable),
        .o_temp_span_code(o_temp_span_code),
        .o_sync_speed_inputs(o_sync_speed_inputs),
        .o_remote1_smoothing_on(o_remote1_smoothing_on),
        .o_remote1_ramp_rate(o_remote1_ramp_rate),
        .o_pwm1_duty(o_pwm1_duty), .o_pwm2_duty(o_pwm2_duty),
        .o_pwm3_duty(o_pwm3_duty));
    fan_load fan_load_inst (.i_ref_clk(i_ref_clk), .i_duty(o_pwm1_duty),
        .o_speed(spd));
    // ==========================================================
    // Helpers
    // ==========================================================
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[15:0], lfsr[16] ^ lfsr[13]};
        return lfsr[7:0];
    endfunction
    function automatic logic [7:0] lim(input int x);
        return (x > 200) ? 8'hC8 : 8'(x);
    endfunction
    function automatic logic [7:0] exp_duty(input logic f, b,
        input logic [7:0] mn, ad);
        return b ? (f ? mn : 8'h00) : ad;
    endfunction
    task automatic wt(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask
    // Holds the request until waitrequest is seen low at a falling edge
    task automatic bus(input logic wr, input logic [6:0] idx,
        input logic [7:0] wd);
        int   n;
        logic w;
        @(posedge i_ref_clk);
        i_address <= {idx, 2'b00};
        i_writedata <= {24'h0, wd};
        i_write <= wr;
        i_read <= ~wr;
        n = 0;
        do begin
            @(negedge i_ref_clk);
            w = o_waitrequest;
            rd = o_readdata[7:0];
            n++;
            @(posedge i_ref_clk);
        end while (w !== 1'b0 && n < 20);
        if (w !== 1'b0) n_mismatch++;
        i_read <= 1'b0;
        i_write <= 1'b0;
    endtask
    task automatic conclude();
        if (n_mismatch == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge i_ref_clk);
        n_mismatch++;
        conclude();
    end
    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        repeat (5) @(posedge i_ref_clk);
        i_rstn <= 1'b1;
        for (int c = 0; c < 3; c++) begin
            bus(1'b0, 7'(IDX_REMOTE1_SLOPE + c), 8'h00);
            `CHK("slope rst", SLOPE_RESET, rd)
        end
        `CHK("rate rst", 9'h124, o_pwm_rate_code)
        `CHK("span rst", 12'hCCC, o_temp_span_code)
        `CHK("stretch rst", 3'h7, o_stretch_enable)
        `CHK("sync rst", 3'h6, o_sync_speed_inputs)
        bus(1'b0, 7'h7F, 8'h00);
        `CHK("unmapped", 8'h00, rd)
        repeat (4) begin
            for (int c = 0; c < 3; c++) begin
                sv[c] = rnd();
                bus(1'b1, 7'(IDX_REMOTE1_SLOPE + c), sv[c]);
            end
            for (int c = 0; c < 3; c++) begin
                bus(1'b0, 7'(IDX_REMOTE1_SLOPE + c), 8'h00);
                `CHK("slope rd", sv[c], rd)
                `CHK("rate", sv[c][2:0], o_pwm_rate_code[c])
                `CHK("fast", sv[c][3], o_fast_drive_select[c])
                `CHK("stretch", ~sv[c][3], o_stretch_enable[c])
                `CHK("span", sv[c][7:4], o_temp_span_code[c])
            end
        end
        i_config_lock <= 1'b1;
        bus(1'b1, IDX_REMOTE1_SLOPE, ~sv[0]);
        bus(1'b0, IDX_REMOTE1_SLOPE, 8'h00);
        `CHK("locked", sv[0], rd)
        i_config_lock <= 1'b0;
        for (int k = 0; k < 6; k++) begin
            v = (k == 0) ? 8'hE0 : ((k == 1) ? 8'h10 : (rnd() & 8'hF7));
            bus(1'b1, IDX_ACOUSTIC_ONE, v);
            i_auto_mode <= (k < 2) ? 3'h7 : 3'(rnd());
            i_below_start <= (k < 2) ? 3'h7 : 3'(rnd());
            i_min_duty <= {rnd(), rnd(), rnd()};
            i_auto_duty <= {rnd(), rnd(), rnd()};
            wt(3);
            for (int c = 0; c < 3; c++)
                `CHK("floor", exp_duty(v[5 + c],
                    i_below_start[c] & i_auto_mode[c], i_min_duty[c],
                    i_auto_duty[c]), dd[c])
            `CHK("sync", {2'b11, v[4]}, o_sync_speed_inputs)
            `CHK("ramp code", v[2:0], o_remote1_ramp_rate)
            `CHK("smooth off", 1'b0, o_remote1_smoothing_on)
            bus(1'b0, IDX_ACOUSTIC_ONE, 8'h00);
            `CHK("acou rd", v, rd)
        end
        @(posedge i_ref_clk);
        i_below_start <= 3'h0;
        for (int c = 0; c < 8; c++) begin
            @(posedge i_ref_clk);
            i_auto_duty[0] <= 8'h00;
            bus(1'b1, IDX_ACOUSTIC_ONE, 8'(c));
            bus(1'b1, IDX_ACOUSTIC_ONE, 8'(8 + c));
            i_auto_duty[0] <= 8'hC8;
            wt(3);
            `CHK("no jump", 1'b1, o_pwm1_duty <= steps[c])
            `CHK("smooth on", 1'b1, o_remote1_smoothing_on)
            wt(10 * SLOT);
            `CHK("ramp mid", 1'b1, o_pwm1_duty >= lim(9 * steps[c]) &&
                o_pwm1_duty <= lim(11 * steps[c]))
            wt((200 / steps[c] + 2) * SLOT);
            `CHK("ramp end", 8'hC8, o_pwm1_duty)
            if (c == 0) `CHK("fan", 8'hC8, spd)
        end
        @(posedge i_ref_clk);
        i_auto_duty[0] <= 8'h00;
        bus(1'b1, IDX_ACOUSTIC_ONE, 8'h00);
        bus(1'b1, IDX_CONFIG_SIX, 8'h80);
        bus(1'b1, IDX_ACOUSTIC_ONE, 8'h08);
        i_auto_duty[0] <= 8'hC8;
        wt(96);
        `CHK("ramp long", 1'b1, o_pwm1_duty inside {[6:9]})
        bus(1'b0, IDX_CONFIG_SIX, 8'h00);
        `CHK("slot bit", 8'h80, rd)
        i_rstn <= 1'b0;
        wt(2);
        `CHK("rate rst2", 9'h124, o_pwm_rate_code)
        conclude();
    end
endmodule // fan_pwm_pwm_rate_code_slope_smoothing_tb_top
`default_nettype wire
